// ### verilog/kpi_keypad_irq_unit.v
/*
  Keypad pin interrupt unit: per-pin enable and polarity, edge or
  edge-and-level sensing, one latched request gated by a mask, pull
  controls, and an AXI4-Lite register slave. Assumes the CPU pulses
  vector_fetch for one aclk cycle when it takes the keypad vector.
*/
`timescale 1ns/1ns
`include "kpi_defines.vh"
module kpi_keypad_irq_unit (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Keypad pins and pad controls
  input  wire [5:0]  key_pin,
  output reg  [5:0]  pin_pullup_q,
  output reg  [5:0]  pin_pulldown_q,
  output reg  [5:0]  pin_force_input_q,
  // CPU side
  input  wire        vector_fetch,
  output reg         key_irq_q,
  output reg         key_wake_q
);
  reg  [5:0] pin_irq_enable_q;
  reg  [5:0] pin_polarity_select_q;
  reg        key_irq_mask_q;
  reg        key_sense_mode_q;
  reg        key_latch_q;
  reg        any_asserted_q;
  reg  [5:0] level_prev_q;
  wire [5:0] level_now;
  wire [5:0] asserted_now;
  wire [5:0] asserted_prev;
  wire [5:0] edge_hit;
  wire       any_edge;
  wire       any_asserted;
  wire       ack_wr;
  wire       ack_pulse;
  wire       latch_d;

  kpi_pin_sync #(.W(`KPI_NPINS)) u_sync (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .pin_raw     (key_pin),
    .pin_level_q (level_now)
  );

  // Polarity folds each level into "asserted"; disabled pins never count
  assign asserted_now  = (level_now ~^ pin_polarity_select_q) & pin_irq_enable_q;
  assign asserted_prev = (level_prev_q ~^ pin_polarity_select_q) & pin_irq_enable_q;
  assign edge_hit      = asserted_now & ~asserted_prev;
  assign any_asserted  = |asserted_now;
  // An edge counts only if no other enabled pin was already asserted
  assign any_edge      = (|edge_hit) & ~(|(asserted_prev & ~edge_hit));

  // Register bus: write happens when both address and data are held
  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ~s_axi_awready;
  // Address bits below bit 2 are ignored, so an unaligned address hits its word; byte lane 0 must be strobed
  wire wr_st = wr_go & ({s_axi_awaddr[3:2], 2'b00} == `KPI_OFS_STATUS) & s_axi_wstrb[0];
  wire wr_en = wr_go & ({s_axi_awaddr[3:2], 2'b00} == `KPI_OFS_ENABLE) & s_axi_wstrb[0];
  wire wr_po = wr_go & ({s_axi_awaddr[3:2], 2'b00} == `KPI_OFS_POLARITY) & s_axi_wstrb[0];
  wire wr_ok = (s_axi_awaddr[3:2] != 2'b11);

  assign ack_wr    = wr_st & s_axi_wdata[`KPI_BIT_ACK];
  assign ack_pulse = ack_wr | vector_fetch;
  // Acknowledge drops the latch, but a new edge in the same cycle wins
  assign latch_d = any_edge | (key_latch_q & ~ack_pulse);

  always @(posedge aclk) begin
    if (!aresetn) begin
      key_latch_q    <= 1'b0;
      level_prev_q   <= 6'h00;
      any_asserted_q <= 1'b0;
    end else begin
      key_latch_q    <= latch_d;
      level_prev_q   <= level_now;
      any_asserted_q <= any_asserted;
    end
  end

  // Request output: level mode also holds the request while any pin is asserted
  wire request = key_latch_q | (key_sense_mode_q & any_asserted_q);

  always @(posedge aclk) begin
    if (!aresetn) begin
      key_irq_q  <= 1'b0;
      key_wake_q <= 1'b0;
    end else begin
      key_irq_q  <= request & ~key_irq_mask_q;
      key_wake_q <= request & ~key_irq_mask_q;
    end
  end

  // Control registers and pad controls
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_irq_enable_q      <= `KPI_RST_PINS;
      pin_polarity_select_q <= `KPI_RST_PINS;
      key_irq_mask_q        <= `KPI_RST_MASK;
      key_sense_mode_q      <= `KPI_RST_MODE;
      pin_pullup_q          <= 6'h00;
      pin_pulldown_q        <= 6'h00;
      pin_force_input_q     <= 6'h00;
    end else begin
      if (wr_st) begin
        key_irq_mask_q   <= s_axi_wdata[`KPI_BIT_MASK];
        key_sense_mode_q <= s_axi_wdata[`KPI_BIT_MODE];
      end
      if (wr_en) begin
        pin_irq_enable_q <= s_axi_wdata[5:0];
      end
      if (wr_po) begin
        pin_polarity_select_q <= s_axi_wdata[5:0];
      end
      pin_pullup_q      <= pin_irq_enable_q & ~pin_polarity_select_q;
      pin_pulldown_q    <= pin_irq_enable_q & pin_polarity_select_q;
      pin_force_input_q <= pin_irq_enable_q;
    end
  end

  // Write channel: take both together, answer one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `KPI_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `KPI_RESP_OKAY : `KPI_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; the acknowledge bit always reads zero
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `KPI_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid & ~s_axi_rvalid & ~s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `KPI_RESP_OKAY;
        case (s_axi_araddr[3:2])
          2'b00: begin
            s_axi_rdata <= {28'h000_0000, key_latch_q, 1'b0,
                            key_irq_mask_q, key_sense_mode_q};
          end
          2'b01: begin
            s_axi_rdata <= {26'h000_0000, pin_irq_enable_q};
          end
          2'b10: begin
            s_axi_rdata <= {26'h000_0000, pin_polarity_select_q};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `KPI_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // kpi_keypad_irq_unit

// ### verilog/kpi_defines.vh
/*
  Register offsets, field positions, reset values and sizes for the keypad
  pin interrupt unit. Assumes a 32-bit AXI4-Lite register bus.

// Functional notes
// - Each keypad pin has its own interrupt enable bit.
// - Polarity bit 0 selects falling/low, 1 selects rising/high.
// - An enabled pin gets a pullup for low sense, pulldown for high sense.
// - Any enabled pin asserting per polarity and mode sets the latch.
// - Edge-only: an edge is ignored while another enabled pin is asserted.
// - Sense mode 1: request stays while any enabled pin is asserted.
// - Mode 1 clear needs acknowledge and all pins deasserted, any order.
// - A keypad vector fetch acknowledges and clears the latch.
// - Writing 1 to the acknowledge bit clears the latch.
// - Edges after an acknowledge latch a fresh request.
// - Request reaches the CPU only while the mask bit is clear.
// - Reset clears the pending request and the sense mode bit.
// - Sense mode 0: edge only, acknowledge clears the latch at once.
// - Pending flag is readable regardless of the mask.
// - An enabled pin is forced to input over its direction bit.
// - Unit stays active in wait and stop; unmasked request wakes the CPU.
// - The acknowledge bit is write-only and reads 0.
// - Six enable and six polarity bits, 5 down to 0, read/write.
*/
`ifndef KPI_DEFINES_VH
`define KPI_DEFINES_VH

`define KPI_NPINS          6
`define KPI_OFS_STATUS     4'h0
`define KPI_OFS_ENABLE     4'h4
`define KPI_OFS_POLARITY   4'h8
`define KPI_BIT_PENDING    3
`define KPI_BIT_ACK        2
`define KPI_BIT_MASK       1
`define KPI_BIT_MODE       0
`define KPI_RST_MASK       1'b0
`define KPI_RST_MODE       1'b0
`define KPI_RST_PINS       6'h00
`define KPI_RESP_OKAY      2'b00
`define KPI_RESP_SLVERR    2'b10

`endif

// ### verilog/kpi_pin_sync.v
/*
  Three-stage synchroniser for one group of keypad pins; a change is taken
  once stages two and three agree. Assumes pins are asynchronous to aclk.
*/
`timescale 1ns/1ns
module kpi_pin_sync #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // Pins and filtered level
  input  wire [W-1:0] pin_raw,
  output reg  [W-1:0] pin_level_q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  genvar i;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Held value moves only when the last two stages agree
  generate
    for (i = 0; i < W; i = i + 1) begin : g_agree
      always @(posedge aclk) begin
        if (!aresetn) begin
          pin_level_q[i] <= 1'b0;
        end else if (s2_q[i] == s3_q[i]) begin
          pin_level_q[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule // kpi_pin_sync

// ### verification/kpi_keypad_model.sv
/*
  Keypad switch model: a pressed key ties its pin to the rail opposite
  its pull. Assumes the pull controls come from the unit.
*/
`timescale 1ns/1ns
module kpi_keypad_model (
  // Clock
  input  wire       aclk,
  // Key presses and pad pulls
  input  wire [5:0] press,
  input  wire [5:0] pull_up,
  input  wire [5:0] pull_dn,
  // Pins
  output wire [5:0] key_pin
);
  reg [5:0] tog_q = 6'h00;
  // Unpulled pins float, so they wander rather than hold a value
  always @(posedge aclk) tog_q <= ~tog_q;
  assign key_pin = (press & pull_dn) | (~press & (pull_up | (~pull_dn & tog_q)));
endmodule // kpi_keypad_model

// ### verification/kpi_unit_monitor.sv
/*
  Port checker for the keypad unit. Assumes one clock, sync reset.
*/
`timescale 1ns/1ns
module kpi_unit_monitor (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus handshakes
  input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire        s_axi_rvalid, s_axi_rready,
  input wire [31:0] s_axi_rdata,
  // Pads and CPU side
  input wire [5:0]  pin_pullup_q, pin_pulldown_q, pin_force_input_q,
  input wire        key_irq_q, key_wake_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
  sequence rd_take; s_axi_arvalid && !s_axi_rvalid; endsequence
  chk_wr_answer: assert property (wr_take |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
    else $error("write not answered");
  chk_rd_answer: assert property (rd_take |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_rdata_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h000_0000)
    else $error("unused read bits set");
  chk_pull_sense: assert property (!(pin_pullup_q & pin_pulldown_q) && (pin_pullup_q | pin_pulldown_q) == pin_force_input_q)
    else $error("pull controls wrong");
  chk_wake_mirror: assert property (key_wake_q == key_irq_q)
    else $error("wake differs from request");
  chk_reset_clear: assert property ($rose(aresetn) |-> !key_irq_q && !key_wake_q)
    else $error("request survived reset");
endmodule // kpi_unit_monitor
bind kpi_keypad_irq_unit kpi_unit_monitor u_mon (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .pin_pullup_q(pin_pullup_q), .pin_pulldown_q(pin_pulldown_q),
  .pin_force_input_q(pin_force_input_q), .key_irq_q(key_irq_q), .key_wake_q(key_wake_q));

// ### verification/tb_top.sv
/*
  Register-level bench for the keypad unit. Assumes the keypad model on pins.
*/
`timescale 1ns/1ns
module tb_top;
  reg         aclk = 0, aresetn = 0, vector_fetch = 0;
  reg  [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  reg  [31:0] s_axi_wdata = 32'h0000_0000;
  reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  reg  [5:0]  press = 6'h00;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        key_irq_q, key_wake_q;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [5:0]  key_pin, pin_pullup_q, pin_pulldown_q, pin_force_input_q;
  integer     fail_count = 0, tests_run = 0;
  kpi_keypad_irq_unit dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .key_pin(key_pin),
    .pin_pullup_q(pin_pullup_q), .pin_pulldown_q(pin_pulldown_q),
    .pin_force_input_q(pin_force_input_q), .vector_fetch(vector_fetch),
    .key_irq_q(key_irq_q), .key_wake_q(key_wake_q));
  kpi_keypad_model keys (.aclk(aclk), .press(press), .pull_up(pin_pullup_q),
    .pull_dn(pin_pulldown_q), .key_pin(key_pin));
  initial forever #2 aclk = ~aclk;
  task give_verdict;
    begin
      if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task check(input [8*8-1:0] nm, input [31:0] exp, input [31:0] got);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task tick(input integer k);
    repeat (k) @(posedge aclk);
  endtask
  task wr(input [3:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      s_axi_bready <= 1'b0;
      check("bresp", (a == 4'hC) ? 2'b10 : 2'b00, s_axi_bresp);
      @(posedge aclk);
    end
  endtask
  task rdc(input [3:0] a, input [31:0] exp, input [8*8-1:0] nm);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b0;
      check("rresp", (a == 4'hC) ? 2'b10 : 2'b00, s_axi_rresp);
      if (a != 4'hC) check(nm, exp, s_axi_rdata);
      @(posedge aclk);
    end
  endtask
  // Far longer than the scripted sequence, so only a hang trips it
  initial begin
    tick(5000);
    fail_count = fail_count + 1;
    give_verdict;
  end
  initial begin
    tick(16);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(4'h0, 0, "status");
    rdc(4'h4, 0, "enable");
    rdc(4'hC, 0, "unmapd");
    wr(4'h0, 2);
    wr(4'h8, 6'h2A);
    wr(4'h4, 6'h3F);
    wr(4'hC, 32'hFFFF_FFFF);
    rdc(4'h8, 6'h2A, "polar");
    check("pullup", 6'h15, pin_pullup_q);
    check("pulldn", 6'h2A, pin_pulldown_q);
    check("forcein", 6'h3F, pin_force_input_q);
    wr(4'h0, 6);
    wr(4'h0, 0);
    rdc(4'h0, 0, "ackread");
    press <= 6'h01;
    tick(10);
    rdc(4'h0, 8, "pending");
    check("irq", 1, key_irq_q);
    check("wake", 1, key_wake_q);
    wr(4'h0, 4);
    rdc(4'h0, 0, "acked");
    press <= 6'h05;
    tick(10);
    rdc(4'h0, 0, "blocked");
    press <= 6'h00;
    tick(10);
    press <= 6'h04;
    tick(10);
    rdc(4'h0, 8, "fresh");
    wr(4'h0, 6);
    press <= 6'h00;
    tick(10);
    press <= 6'h02;
    tick(10);
    rdc(4'h0, 32'hA, "masked");
    check("nomask", 0, key_irq_q);
    vector_fetch <= 1'b1;
    @(posedge aclk);
    vector_fetch <= 1'b0;
    rdc(4'h0, 2, "fetched");
    press <= 6'h00;
    tick(10);
    wr(4'h0, 1);
    press <= 6'h08;
    tick(10);
    wr(4'h0, 5);
    tick(4);
    check("hold", 1, key_irq_q);
    press <= 6'h00;
    tick(10);
    check("idle", 0, key_irq_q);
    press <= 6'h08;
    tick(10);
    press <= 6'h00;
    tick(10);
    check("latched", 1, key_irq_q);
    wr(4'h0, 5);
    tick(3);
    check("cleared", 0, key_irq_q);
    press <= 6'h08;
    tick(10);
    aresetn <= 1'b0;
    tick(4);
    aresetn <= 1'b1;
    tick(2);
    check("rstirq", 0, key_irq_q);
    rdc(4'h0, 0, "rststat");
    give_verdict;
  end
endmodule // tb_top
